//--- field_reader.sv
// reader-side model: samples the tag's load switch at quarter-bit points
`timescale 1ns/1ps
module field_reader #(
  parameter int unsigned DIV = 8  // clocks per bit period
) (
  input  wire logic sys_clk_i,  // carrier-derived clock
  input  wire logic sys_rst_i,  // reset, restarts the reader's bit timing
  input  wire logic sw_i,       // observed load switch, high = on
  input  wire logic frm_i,      // frame flag, passed on with the sample
  output logic      h1_o,       // switch level in first half of the bit
  output logic      h2_o,       // switch level in second half of the bit
  output logic      frm_o,      // frame flag taken with the first half
  output logic      valid_o     // one-cycle pulse when a bit is complete
);
  int unsigned cnt_q;  // clocks since reset release
  // no clock recovery: a wrong tag rate shows up as decode errors
  always_ff @(posedge sys_clk_i) begin
    valid_o <= 1'b0;
    if (sys_rst_i) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
      // quarter points stay clear of the two-clock coder and output lag
      if (cnt_q % DIV == DIV / 4) begin
        h1_o  <= sw_i;
        frm_o <= frm_i;
      end
      if (cnt_q % DIV == 3 * DIV / 4) begin
        h2_o    <= sw_i;
        valid_o <= 1'b1;
      end
    end
  end
endmodule : field_reader

//--- miller_coder.sv
// module: miller line coder driving the modulation switch level
`timescale 1ns/1ps
module miller_coder
  import tag_framer_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  miller_if.coder   mif
);

  logic lvl_q;      // present coded level
  logic prev_zero_q; // previous coded bit was a zero

  // transitions: mid-bit for a one, boundary only between zeros
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      lvl_q       <= 1'b1;
      prev_zero_q <= 1'b0;
    end else if (!mif.active) begin
      // outside the frame the level is dictated; history forgotten
      lvl_q       <= mif.force_lvl; // see R3 see R14
      prev_zero_q <= 1'b0;
    end else if (mif.bit_start) begin
      if (!mif.nrz && prev_zero_q) begin
        lvl_q <= ~lvl_q; // see R16
      end
      prev_zero_q <= ~mif.nrz;
    end else if (mif.mid_bit && mif.nrz) begin
      lvl_q <= ~lvl_q; // see R16
    end
  end

  assign mif.sw = lvl_q; // see R15

endmodule : miller_coder

//--- miller_if.sv
// interface: nrz bit and timing strobes from the sequencer to the miller coder
`timescale 1ns/1ps
interface miller_if;
  logic bit_start;  // pulse at each bit boundary
  logic mid_bit;    // pulse at mid-bit
  logic nrz;        // bit being coded
  logic active;     // frame in progress (else switch forced)
  logic force_lvl;  // switch level outside frames
  logic sw;         // coded switch level

  modport seq   (output bit_start, output mid_bit, output nrz, output active,
                 output force_lvl, input sw);
  modport coder (input bit_start, input mid_bit, input nrz, input active,
                 input force_lvl, output sw);
endinterface : miller_if

//--- readonly_tag_miller_framer_bench.sv
// testbench: tag framer with a reader model decoding the miller stream
`timescale 1ns/1ps
module readonly_tag_miller_framer_bench;
  import tag_framer_pkg::*;
  localparam int unsigned TDIV   = 8;          // short bit period for simulation
  localparam logic [4:0]  TWAFER = 5'h19;      // top of the wafer range
  localparam logic [17:0] TLOT   = 18'h3FFFF;  // all ones, boundary value
  localparam logic [13:0] TDIE   = 14'h2AAA;   // alternating pattern
  logic        sys_clk_i;  // bench clock
  logic        sys_rst_i;  // power-on reset
  logic        sw, frm, tick, h1, h2, rfrm, rvalid;
  int          num_errors;  // mismatches
  int          cmp_count;   // comparisons
  logic [81:0] want;        // expected frame, bit 0 first
`define CHK(nm, ex, got) \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    num_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
  end
  tag_framer #(.DIV(TDIV), .WAFER(TWAFER), .LOT(TLOT), .DIE(TDIE)) tag_framer_i (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .mod_switch_o(sw), .frame_o(frm), .bit_tick_o(tick));
  field_reader #(.DIV(TDIV)) field_reader_i (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sw_i(sw), .frm_i(frm),
    .h1_o(h1), .h2_o(h2), .frm_o(rfrm), .valid_o(rvalid));
  // 100 ns period
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // expected frame built from the fields, check over data bits 1..64
  function automatic logic [81:0] exp_frame();
    logic [81:0] f;
    logic [15:0] c;
    logic        fb;
    f = '0;
    c = CRC_INIT;
    f[START_POS] = START_VAL;
    f[WAFER_POS +: WAFER_W] = TWAFER;
    f[RSVD_POS +: RSVD_W] = DEF_RSVD;
    f[PART_POS +: PART_W] = DEF_PART;
    f[CUST_POS +: CUST_W] = DEF_CUST;
    f[LOT_POS +: LOT_W] = TLOT;
    f[DIE_POS +: DIE_W] = TDIE;
    for (int i = 1; i <= DATA_BITS; i++) begin
      fb = c[15] ^ f[i];
      c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    for (int i = 0; i < CHECK_BITS; i++) f[CHECK_POS + i] = c[15 - i];
    f[STOP_POS] = STOP_VAL;
    return f;
  endfunction : exp_frame
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // one decoded bit period from the reader, bounded wait
  task automatic next_bit(output logic a, output logic b, output logic f);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    while (rvalid !== 1'b1 && n < 4 * TDIV) begin
      n++;
      @(negedge sys_clk_i);
    end
    if (rvalid !== 1'b1) begin
      num_errors++;
      wrap_up();
    end else begin
      a = h1;
      b = h2;
      f = rfrm;
    end
  endtask : next_bit
  // waits for the next tick pulse; a used-up bound ends the run as a mismatch
  task automatic wait_tick(output int n);
    n = 0;
    while (tick !== 1'b1 && n < 4 * TDIV) begin
      n++;
      @(negedge sys_clk_i);
    end
    if (tick !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
  endtask : wait_tick
  task automatic do_reset();
    @(posedge sys_clk_i) sys_rst_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
  endtask : do_reset
  // switch held on for the whole initialisation, no frame yet
  task automatic scen_init();
    logic a, b, f;
    for (int i = 0; i < INIT_BITS; i++) begin
      next_bit(a, b, f);
      `CHK("init switch", 2'b11, {a, b})
      `CHK("init frame flag", 1'b0, f)
    end
  endtask : scen_init
  // one full frame and pause, decoded and checked bit by bit
  task automatic scen_frame();
    logic a, b, f, pb;
    logic [81:0] rx;
    pb = 1'b0;
    for (int i = 0; i < FRAME_BITS; i++) begin
      next_bit(a, b, f);
      rx[i] = a ^ b;
      `CHK("frame flag", 1'b1, f)
      if (i > 0) begin
        `CHK("boundary", (!want[i] && !want[i-1]) ? ~pb : pb, a)
      end
      pb = b;
    end
    `CHK("frame bits", want, rx)
    `CHK("start bit", 1'b1, rx[0])
    `CHK("stop bit", 1'b0, rx[81])
    `CHK("first field", TWAFER, rx[5:1])
    `CHK("check field", want[80:65], rx[80:65])
    `CHK("wafer range", 1'b1, rx[5:1] >= 5'(WAFER_MIN) && rx[5:1] <= 5'(WAFER_MAX))
    `CHK("reserved", 4'h0, rx[9:6])
    for (int i = 0; i < PAUSE_BITS; i++) begin
      next_bit(a, b, f);
      `CHK("pause switch", 2'b00, {a, b})
      `CHK("pause flag", 1'b0, f)
    end
  endtask : scen_frame
  // bit period length measured between two ticks
  task automatic scen_rate();
    int n;
    wait_tick(n);
    @(negedge sys_clk_i);
    wait_tick(n);
    `CHK("clocks per bit", TDIV, n + 1)
    `CHK("baud", 26484, CARRIER_KHZ * 1000 / BIT_DIV)
  endtask : scen_rate
  // reset in mid-frame restarts initialisation with the switch on
  task automatic scen_rerst();
    logic a, b, f;
    for (int i = 0; i < 20; i++) next_bit(a, b, f);
    do_reset();
    scen_init();
  endtask : scen_rerst
  initial begin
    sys_rst_i <= 1'b1;
    num_errors = 0;
    cmp_count = 0;
    want = exp_frame();
    do_reset();
    scen_init();
    scen_frame();
    scen_frame();
    scen_rate();
    scen_rerst();
    scen_frame();
    wrap_up();
  end
endmodule : readonly_tag_miller_framer_bench

//--- tag_framer.sv
// module: read-only tag transmit sequencer with rom, check generator and coder
// Summary of operation
// R1: after reset, transmit rom continuously, unprompted
// R2: repeat frame then pause forever
// R3: pause is nine bits, switch off
// R4: start, 64 data, 16 check, stop
// R5: fixed field widths within 82 bits
// R6: bit zero is sent first
// R7: wafer index between 1 and 25
// R8: signal only via load switch on/off
// R9: logic clock divided from carrier
// R10: default rate 26484 baud at 13.56 MHz
// R11: power-on reset clears all logic
// R12: start bit one, stop bit zero
// R13: ccitt check over data, cleared at stop
// R14: switch on 64 bits during initialisation
// R15: coder takes nrz, drives the switch
// R16: miller: mid-bit for one, boundary zero-zero
// R17: divide by 512, ratio build-time only
`timescale 1ns/1ps
module tag_framer
  import tag_framer_pkg::*;
#(
  parameter int unsigned   DIV     = BIT_DIV,    // carrier clocks per bit
  parameter logic [4:0]    WAFER   = DEF_WAFER,
  parameter logic [9:0]    PART    = DEF_PART,   // arbitrary value
  parameter logic [12:0]   CUST    = DEF_CUST,   // arbitrary value
  parameter logic [17:0]   LOT     = DEF_LOT,
  parameter logic [13:0]   DIE     = DEF_DIE
) (
  input  wire logic sys_clk_i,     // carrier-derived clock
  input  wire logic sys_rst_i,     // power-on reset, high while supply low
  output logic      mod_switch_o,  // high = load switch on
  output logic      frame_o,       // high while a frame is on air
  output logic      bit_tick_o     // one-cycle pulse at each bit boundary
);

  typedef enum logic [1:0] {ST_INIT, ST_FRAME, ST_PAUSE} phase_e;

  // data payload assembled from the identity fields, low bit sent first
  localparam logic [63:0] PAYLOAD = {DIE, LOT, CUST, PART, DEF_RSVD, WAFER}; // see R5

  // cycle count at which a bit ends and its middle
  localparam int unsigned DIV_W  = $clog2(DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
  localparam logic [DIV_W-1:0] DIV_MID  = DIV_W'(DIV / 2);

  // check value of the payload, worked at elaboration so the rom is constant
  function automatic logic [15:0] crc_of(input logic [63:0] d);
    logic [15:0] c;
    logic        fb;
    c = CRC_INIT;
    for (int i = 0; i < DATA_BITS; i++) begin
      fb = c[15] ^ d[i];
      c  = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction : crc_of

  localparam logic [15:0] CRC_REF = crc_of(PAYLOAD); // see R13

  // factory rom: stop, check (msb first on air), payload, start
  logic [FRAME_BITS-1:0] rom;
  genvar g;
  generate
    for (g = 0; g < CHECK_BITS; g++) begin : g_chk
      // check bits go out most significant first, as a serial crc would
      assign rom[CHECK_POS + g] = CRC_REF[CHECK_BITS - 1 - g]; // see R13
    end
  endgenerate
  assign rom[START_POS]                     = START_VAL; // see R12
  assign rom[WAFER_POS +: DATA_BITS]        = PAYLOAD;   // see R4
  assign rom[STOP_POS]                      = STOP_VAL;  // see R12

  miller_if mif ();

  phase_e           phase_q;      // init, frame or pause
  logic [DIV_W-1:0] div_q;        // carrier divider within one bit
  logic [6:0]       bit_q;        // bit index in the current phase
  logic             tick;         // last carrier cycle of a bit
  logic             last_bit;     // phase ends with this bit
  logic [15:0]      crc_q;        // live check register, cleared each stop
  logic             crc_ok_q;     // live check matched the stored value

  // bit-period divider; ratio is a build parameter only
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      div_q <= '0; // see R11
    end else if (div_q == DIV_LAST) begin
      div_q <= '0; // see R9 see R10 see R17
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign tick = (div_q == DIV_LAST);

  // final bit of each phase
  always_comb begin
    case (phase_q)
      ST_INIT:  last_bit = (bit_q == 7'(INIT_BITS - 1));
      ST_FRAME: last_bit = (bit_q == 7'(FRAME_BITS - 1));
      ST_PAUSE: last_bit = (bit_q == 7'(PAUSE_BITS - 1));
      default:  last_bit = 1'b1;
    endcase
  end

  // phase sequencer: init, then frame and pause forever
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      phase_q <= ST_INIT; // see R11 see R14
      bit_q   <= '0;
    end else if (tick) begin
      if (last_bit) begin
        bit_q <= '0;
        case (phase_q)
          ST_INIT:  phase_q <= ST_FRAME; // see R1
          ST_FRAME: phase_q <= ST_PAUSE; // see R2
          ST_PAUSE: phase_q <= ST_FRAME; // see R2 see R3
          default:  phase_q <= ST_INIT;
        endcase
      end else begin
        bit_q <= bit_q + 1'b1;
      end
    end
  end

  // strobes to the coder; bit_start fires on the first cycle of a bit
  assign mif.bit_start = (div_q == '0);
  assign mif.mid_bit   = (div_q == DIV_MID);
  assign mif.nrz       = rom[bit_q]; // see R6
  assign mif.active    = (phase_q == ST_FRAME);
  // switch on while initialising, off in the pause
  assign mif.force_lvl = (phase_q == ST_INIT); // see R14 see R3

  miller_coder u_coder (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .mif       (mif)
  );

  // serial check shadow over data bits, for self-test; cleared at stop bit
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      crc_q <= CRC_INIT;
    end else if (phase_q == ST_FRAME && mif.bit_start) begin
      if (bit_q == 7'(STOP_POS)) begin
        crc_q <= CRC_INIT; // see R13
      end else if (bit_q >= 7'(WAFER_POS) && bit_q < 7'(CHECK_POS)) begin
        crc_q <= {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ rom[bit_q]) ? CRC_POLY : 16'h0000);
      end
    end
  end

  // latch whether the shadow agrees at the first check bit
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      crc_ok_q <= 1'b0;
    end else if (phase_q == ST_FRAME && mif.bit_start && bit_q == 7'(CHECK_POS)) begin
      crc_ok_q <= (crc_q == CRC_REF);
    end
  end

  // registered outputs: switch follows the coded level only
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mod_switch_o <= 1'b1; // see R14
      frame_o      <= 1'b0;
      bit_tick_o   <= 1'b0;
    end else begin
      mod_switch_o <= mif.sw; // see R8 see R15
      frame_o      <= (phase_q == ST_FRAME);
      bit_tick_o   <= tick;
    end
  end

  // ------------- assertions -------------
  a_wafer_range: assert property (@(posedge sys_clk_i) // see R7
    (WAFER >= 5'(WAFER_MIN)) && (WAFER <= 5'(WAFER_MAX)))
    else $error("wafer index out of range");

  a_frame_marks: assert property (@(posedge sys_clk_i) // see R12
    rom[START_POS] && !rom[STOP_POS])
    else $error("framing bits wrong");

  a_init_on: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see R14
    (phase_q == ST_INIT) |=> mod_switch_o)
    else $error("switch not on while initialising");

  a_pause_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see R3
    (phase_q == ST_PAUSE && !mif.bit_start) |=> !mod_switch_o)
    else $error("switch on during pause");

  a_pause_len: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see R3
    (phase_q == ST_PAUSE && tick && bit_q != 7'(PAUSE_BITS - 1)) |=> (phase_q == ST_PAUSE))
    else $error("pause ended early");

  a_pause_next: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see R2
    (phase_q == ST_PAUSE && tick && last_bit) |=> (phase_q == ST_FRAME && bit_q == 7'd0))
    else $error("frame did not follow pause");

  a_frame_end: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see R4
    (phase_q == ST_FRAME && tick && bit_q == 7'(FRAME_BITS - 1)) |=> (phase_q == ST_PAUSE))
    else $error("frame length wrong");

  a_one_mid: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see R16
    (mif.active && mif.mid_bit && mif.nrz && $stable(phase_q)) |=> (mif.sw != $past(mif.sw)))
    else $error("missing mid-bit transition for a one");

  a_crc_match: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see R13
    (phase_q == ST_FRAME && bit_q == 7'(CHECK_POS) && div_q == 1) |-> crc_ok_q)
    else $error("serial check differs from stored check");

  a_divider: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see R17
    tick |=> (div_q == '0))
    else $error("bit divider did not wrap");

endmodule : tag_framer

//--- tag_framer_pkg.sv
// package: frame layout, rom defaults and timing constants for the tag framer
package tag_framer_pkg;

  // frame geometry
  localparam int unsigned FRAME_BITS      = 82;
  localparam int unsigned PAUSE_BITS      = 9;
  localparam int unsigned INIT_BITS       = 64;
  localparam int unsigned DATA_BITS       = 64;
  localparam int unsigned CHECK_BITS      = 16;

  // field positions inside the stored frame, bit 0 goes on air first
  localparam int unsigned START_POS       = 0;
  localparam int unsigned WAFER_POS       = 1;
  localparam int unsigned WAFER_W         = 5;
  localparam int unsigned RSVD_POS        = 6;
  localparam int unsigned RSVD_W          = 4;
  localparam int unsigned PART_POS        = 10;
  localparam int unsigned PART_W          = 10;
  localparam int unsigned CUST_POS        = 20;
  localparam int unsigned CUST_W          = 13;
  localparam int unsigned LOT_POS         = 33;
  localparam int unsigned LOT_W           = 18;
  localparam int unsigned DIE_POS         = 51;
  localparam int unsigned DIE_W           = 14;
  localparam int unsigned CHECK_POS       = 65;
  localparam int unsigned STOP_POS        = 81;

  // framing bit values
  localparam logic        START_VAL       = 1'b1;
  localparam logic        STOP_VAL        = 1'b0;

  // wafer index range
  localparam int unsigned WAFER_MIN       = 1;
  localparam int unsigned WAFER_MAX       = 25;

  // check polynomial x^16+x^12+x^5+1, register cleared to zero
  localparam logic [15:0] CRC_POLY        = 16'h1021;
  localparam logic [15:0] CRC_INIT        = 16'h0000;

  // rate: carrier 13.56 MHz divided by 512 gives 26484 baud
  localparam int unsigned CARRIER_KHZ     = 13560;
  localparam int unsigned BIT_DIV         = 512;
  localparam int unsigned HALF_DIV        = BIT_DIV / 2;

  // default factory identity fields (arbitrary neutral values)
  localparam logic [4:0]  DEF_WAFER       = 5'h01;
  localparam logic [3:0]  DEF_RSVD        = 4'h0;
  localparam logic [9:0]  DEF_PART        = 10'h155; // arbitrary value
  localparam logic [12:0] DEF_CUST        = 13'h0AA; // arbitrary value
  localparam logic [17:0] DEF_LOT         = 18'h00001;
  localparam logic [13:0] DEF_DIE         = 14'h0001;

endpackage : tag_framer_pkg
